/* File: hw/coar_map.svh */
`ifndef COAR_MAP_SVH
`define COAR_MAP_SVH

// special function register byte addresses
`define COAR_SFR_ACC 8'hE0
`define COAR_SFR_PSW 8'hD0
`define COAR_SFR_DPL 8'h82
`define COAR_SFR_DPH 8'h83

// program status word bank-select field
`define COAR_PSW_BANK_LO 3
`define COAR_PSW_BANK_HI 4

// internal RAM layout
`define COAR_IRAM_SFR_BIT 7
`define COAR_REGS_TOP 8'h20
`define COAR_BIT_RAM_BASE 8'h20
`define COAR_BIT_CARRY 8'hD7

// opcodes that break the nibble pattern
`define COAR_OP_RESERVED 8'hA5

// cycle counts
`define COAR_CYC_ONE 3'h1
`define COAR_CYC_TWO 3'h2
`define COAR_CYC_THREE 3'h3
`define COAR_CYC_SIX 3'h6

`endif

/* File: hw/coar_pkg.sv */
`default_nettype none

package coar_pkg;

    typedef enum logic [3:0] {
        SP_NONE,
        SP_IRAM,
        SP_SFR,
        SP_XDATA,
        SP_CODE,
        SP_IMM,
        SP_ACC,
        SP_BIT,
        SP_DATA_POINTER_REG
    } coar_space_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [15:0] data_pointer_reg;
        logic [1:0] bank;
        logic [31:0][7:0] bank_general_regs;
        logic valid;
        coar_space_t space;
        logic [15:0] addr;
        logic [15:0] imm;
        logic [2:0] bit_idx;
        logic [2:0] cycles;
        logic reserved;
    } coar_state_t;

endpackage : coar_pkg

`default_nettype wire

/* File: hw/coar_bitmap.sv */
`include "coar_map.svh"
`default_nettype none

module coar_bitmap (
    // bit address in
    input wire logic [7:0] i_bit_addr,
    // resolved location
    output logic [7:0] o_byte_addr,
    output logic [2:0] o_bit_idx
);

    always_comb begin
        o_bit_idx = i_bit_addr[2:0];
        if (i_bit_addr[`COAR_IRAM_SFR_BIT]) begin
            // upper half: sfrs whose address ends in 0 or 8
            o_byte_addr = {i_bit_addr[7:3], 3'h0};
        end else begin
            o_byte_addr = 8'(`COAR_BIT_RAM_BASE + {4'h0, i_bit_addr[6:3]});
        end
    end

endmodule : coar_bitmap

`default_nettype wire

/* File: hw/coar_resolver.sv */
`include "coar_map.svh"
`default_nettype none

module coar_resolver #(
    parameter int unsigned CODE_AW = 16
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // instruction to resolve
    input wire logic i_dec_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_op1,
    input wire logic [7:0] i_op2,
    input wire logic [15:0] i_pc,
    // write-back snoop from the execute stage
    input wire logic i_wr_en,
    input wire logic i_wr_sfr,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    // resolved operand
    output logic o_valid,
    output coar_pkg::coar_space_t o_space,
    output logic [15:0] o_addr,
    output logic [15:0] o_imm,
    output logic [2:0] o_bit_idx,
    output logic [2:0] o_cycles,
    output logic o_reserved,
    // architectural state
    output logic [7:0] o_acc,
    output logic [15:0] o_data_pointer_reg,
    output logic [1:0] o_bank
);

    // code addresses narrower than a byte or wider than the data pointer cannot be served
    if (CODE_AW < 8 || CODE_AW > 16) begin : g_bad_code_aw
        $error("coar_resolver: CODE_AW must lie in 8..16");
    end

    localparam logic [15:0] CODE_MASK = 16'((32'h1 << CODE_AW) - 32'h1);

    coar_pkg::coar_state_t s_reg;
    coar_pkg::coar_state_t s_next;

    logic [7:0] bit_src;
    logic [7:0] bit_byte;
    logic [2:0] bit_idx;
    logic [4:0] rn_idx;
    logic [4:0] ri_idx;
    logic [7:0] ri_val;
    logic imm_in_op1;

    coar_bitmap u_bitmap (
        .i_bit_addr(bit_src),
        .o_byte_addr(bit_byte),
        .o_bit_idx(bit_idx)
    );

    // carry ops reach the status word bit through the same bit path
    assign bit_src = (i_opcode[3:0] == 4'h3) ? `COAR_BIT_CARRY : i_op1;

    always_comb begin
        s_next = s_reg;
        rn_idx = {s_reg.bank, i_opcode[2:0]};
        ri_idx = {s_reg.bank, 2'b00, i_opcode[0]};
        ri_val = s_reg.bank_general_regs[ri_idx];
        // mov #, cjne # forms carry a constant next to an Rn or @Ri operand
        imm_in_op1 = (i_opcode[7:4] == 4'h7) || (i_opcode[7:4] == 4'hB);
        s_next.valid = i_dec_valid;
        if (i_dec_valid) begin
            s_next.space = coar_pkg::SP_NONE;
            s_next.addr = 16'h0000;
            s_next.imm = 16'h0000;
            s_next.bit_idx = 3'h0;
            s_next.cycles = `COAR_CYC_TWO;
            s_next.reserved = 1'b0;
            if (i_opcode[3]) begin
                s_next.space = coar_pkg::SP_IRAM;
                s_next.addr = {11'h000, rn_idx};
                s_next.cycles = `COAR_CYC_ONE;
                if (imm_in_op1) begin
                    s_next.imm = {8'h00, i_op1};
                end
            end else begin
                unique case (i_opcode[2:0])
                    3'h6, 3'h7: begin
                        s_next.space = coar_pkg::SP_IRAM;
                        s_next.addr = {8'h00, ri_val};
                        if (imm_in_op1) begin
                            s_next.imm = {8'h00, i_op1};
                        end
                    end
                    3'h5: begin
                        if (i_opcode == `COAR_OP_RESERVED) begin
                            s_next.reserved = 1'b1;
                        end else begin
                            // the address byte never leaves the core spaces
                            s_next.space = i_op1[`COAR_IRAM_SFR_BIT] ? coar_pkg::SP_SFR
                                                                     : coar_pkg::SP_IRAM;
                            s_next.addr = {8'h00, i_op1};
                            if (i_opcode[7:4] == 4'h7) begin
                                s_next.imm = {8'h00, i_op2};
                            end
                        end
                    end
                    3'h4: begin
                        unique case (i_opcode[7:4])
                            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB: begin
                                s_next.space = coar_pkg::SP_IMM;
                                s_next.imm = {8'h00, i_op1};
                            end
                            default: begin
                                s_next.space = coar_pkg::SP_ACC;
                                s_next.addr = {8'h00, `COAR_SFR_ACC};
                                if (i_opcode[7:4] == 4'h8) begin
                                    s_next.cycles = `COAR_CYC_SIX;
                                end else if (i_opcode[7:4] == 4'hD) begin
                                    s_next.cycles = `COAR_CYC_THREE;
                                end else if (i_opcode[7:4] != 4'hA) begin
                                    s_next.cycles = `COAR_CYC_ONE;
                                end
                            end
                        endcase
                    end
                    3'h3: begin
                        unique case (i_opcode[7:4])
                            4'h0, 4'h1, 4'h2, 4'h3: begin
                                s_next.space = coar_pkg::SP_ACC;
                                s_next.addr = {8'h00, `COAR_SFR_ACC};
                                s_next.cycles = `COAR_CYC_ONE;
                            end
                            4'h4, 4'h5, 4'h6: begin
                                s_next.space = i_op1[`COAR_IRAM_SFR_BIT] ? coar_pkg::SP_SFR
                                                                         : coar_pkg::SP_IRAM;
                                s_next.addr = {8'h00, i_op1};
                                s_next.imm = {8'h00, i_op2};
                            end
                            4'h7, 4'h9: begin
                                // jump target or table read, both code space
                                s_next.space = coar_pkg::SP_CODE;
                                s_next.addr = 16'(s_reg.data_pointer_reg
                                                  + {8'h00, s_reg.acc}) & CODE_MASK;
                            end
                            4'h8: begin
                                s_next.space = coar_pkg::SP_CODE;
                                s_next.addr = 16'(i_pc + {8'h00, s_reg.acc}) & CODE_MASK;
                            end
                            4'hA: begin
                                s_next.space = coar_pkg::SP_DATA_POINTER_REG;
                                s_next.cycles = `COAR_CYC_ONE;
                            end
                            4'hB, 4'hC, 4'hD: begin
                                s_next.space = coar_pkg::SP_BIT;
                                s_next.addr = {8'h00, bit_byte};
                                s_next.bit_idx = bit_idx;
                                s_next.cycles = `COAR_CYC_ONE;
                            end
                            default: begin
                                s_next.space = coar_pkg::SP_XDATA;
                                s_next.addr = {8'h00, ri_val};
                            end
                        endcase
                    end
                    3'h2: begin
                        unique case (i_opcode[7:4])
                            4'h0, 4'h1, 4'h2, 4'h3: begin
                                s_next.space = coar_pkg::SP_NONE;
                            end
                            4'h4, 4'h5, 4'h6: begin
                                s_next.space = i_op1[`COAR_IRAM_SFR_BIT] ? coar_pkg::SP_SFR
                                                                         : coar_pkg::SP_IRAM;
                                s_next.addr = {8'h00, i_op1};
                            end
                            4'hE, 4'hF: begin
                                s_next.space = coar_pkg::SP_XDATA;
                                s_next.addr = {8'h00, ri_val};
                            end
                            default: begin
                                s_next.space = coar_pkg::SP_BIT;
                                s_next.addr = {8'h00, bit_byte};
                                s_next.bit_idx = bit_idx;
                            end
                        endcase
                    end
                    3'h0: begin
                        unique case (i_opcode[7:4])
                            4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin
                                s_next.space = coar_pkg::SP_BIT;
                                s_next.addr = {8'h00, bit_byte};
                                s_next.bit_idx = bit_idx;
                            end
                            4'hC, 4'hD: begin
                                s_next.space = i_op1[`COAR_IRAM_SFR_BIT] ? coar_pkg::SP_SFR
                                                                         : coar_pkg::SP_IRAM;
                                s_next.addr = {8'h00, i_op1};
                            end
                            4'hE, 4'hF: begin
                                s_next.space = coar_pkg::SP_XDATA;
                                s_next.addr = s_reg.data_pointer_reg;
                            end
                            4'h9: begin
                                s_next.space = coar_pkg::SP_IMM;
                                s_next.imm = {i_op1, i_op2};
                            end
                            default: begin
                                s_next.space = coar_pkg::SP_NONE;
                            end
                        endcase
                    end
                    default: begin
                        // absolute jumps and calls carry no data operand
                        s_next.space = coar_pkg::SP_NONE;
                    end
                endcase
            end
        end
        // write-back lands after the decode above, so it shows from the next instruction
        if (i_wr_en) begin
            if (!i_wr_sfr) begin
                if (i_wr_addr < `COAR_REGS_TOP) begin
                    s_next.bank_general_regs[i_wr_addr[4:0]] = i_wr_data;
                end
            end else begin
                unique case (i_wr_addr)
                    `COAR_SFR_ACC: s_next.acc = i_wr_data;
                    `COAR_SFR_PSW: begin
                        s_next.bank = i_wr_data[`COAR_PSW_BANK_HI:`COAR_PSW_BANK_LO];
                    end
                    `COAR_SFR_DPL: s_next.data_pointer_reg[7:0] = i_wr_data;
                    `COAR_SFR_DPH: s_next.data_pointer_reg[15:8] = i_wr_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_reg <= coar_pkg::coar_state_t'('0);
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_valid = s_reg.valid;
    assign o_space = s_reg.space;
    assign o_addr = s_reg.addr;
    assign o_imm = s_reg.imm;
    assign o_bit_idx = s_reg.bit_idx;
    assign o_cycles = s_reg.cycles;
    assign o_reserved = s_reg.reserved;
    assign o_acc = s_reg.acc;
    assign o_data_pointer_reg = s_reg.data_pointer_reg;
    assign o_bank = s_reg.bank;

endmodule : coar_resolver

`default_nettype wire

/* File: tb/coar_resolver_monitor.sv */
`include "coar_map.svh"
`default_nettype none

module coar_resolver_checker #(
    parameter int unsigned CODE_AW = 16
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // watched inputs
    input wire logic i_dec_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_op1,
    input wire logic i_wr_en,
    // watched outputs
    input wire logic o_valid,
    input wire coar_pkg::coar_space_t o_space,
    input wire logic [15:0] o_addr,
    input wire logic [15:0] o_imm,
    input wire logic [2:0] o_bit_idx,
    input wire logic [2:0] o_cycles,
    input wire logic o_reserved,
    input wire logic [7:0] o_acc,
    input wire logic [15:0] o_data_pointer_reg,
    input wire logic [1:0] o_bank
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CODE_MASK = 16'hFFFF >> (16 - CODE_AW);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_valid;
        i_dec_valid |=> o_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("missing result");
    property p_idle;
        !i_dec_valid |=> !o_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("spurious result");
    property p_direct;
        i_dec_valid && i_opcode == 8'hE5 |=> o_addr == {8'h00, $past(i_op1)} &&
            o_space == ($past(i_op1) < 8'h80 ? coar_pkg::SP_IRAM : coar_pkg::SP_SFR);
    endproperty
    a_direct: assert property (p_direct) else $error("direct mode wrong");
    property p_data_pointer_reg_ind;
        i_dec_valid && i_opcode == 8'hE0 |=>
            o_space == coar_pkg::SP_XDATA && o_addr == $past(o_data_pointer_reg);
    endproperty
    a_data_pointer_reg_ind: assert property (p_data_pointer_reg_ind) else $error("16-bit indirect wrong");
    property p_indexed;
        i_dec_valid && i_opcode == 8'h93 |=> o_space == coar_pkg::SP_CODE &&
            o_addr == (($past(o_data_pointer_reg) + 16'($past(o_acc))) & CODE_MASK);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed read wrong");
    property p_bit;
        i_dec_valid && i_opcode == 8'hC2 |=> o_space == coar_pkg::SP_BIT &&
            o_bit_idx == $past(i_op1[2:0]) && o_addr == ($past(i_op1[7]) ?
            {8'h00, $past(i_op1) & 8'hF8} : {8'h00, 8'h20 + 8'($past(i_op1[6:3]))});
    endproperty
    a_bit: assert property (p_bit) else $error("bit mode wrong");
    property p_acc;
        i_dec_valid && i_opcode == 8'hE4 |=> o_space == coar_pkg::SP_ACC && o_addr == 16'h00E0;
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator op wrong");
    property p_imm;
        i_dec_valid && i_opcode == 8'h74 |=> o_space == coar_pkg::SP_IMM &&
            o_imm == {8'h00, $past(i_op1)};
    endproperty
    a_imm: assert property (p_imm) else $error("immediate wrong");
    property p_cycles;
        o_valid |-> o_cycles inside {3'h1, 3'h2, 3'h3, 3'h6};
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle figure out of range");
    property p_bank;
        !i_wr_en |=> $stable(o_bank);
    endproperty
    a_bank: assert property (p_bank) else $error("bank moved without write");
    property p_regbank;
        i_dec_valid && i_opcode[3] |=> o_space == coar_pkg::SP_IRAM &&
            o_addr == {11'h000, $past(o_bank), $past(i_opcode[2:0])};
    endproperty
    a_regbank: assert property (p_regbank) else $error("register mode wrong");
    property p_reserved;
        i_dec_valid && i_opcode == 8'hA5 |=> o_reserved && o_space == coar_pkg::SP_NONE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not flagged");
    property p_reset;
        disable iff (1'b0) i_rst |=> o_acc == 8'h00 && o_data_pointer_reg == 16'h0000 &&
            o_bank == 2'h0 && o_space == coar_pkg::SP_NONE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : coar_resolver_checker

bind coar_resolver coar_resolver_checker #(.CODE_AW(CODE_AW)) coar_resolver_checker_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_dec_valid(i_dec_valid), .i_opcode(i_opcode),
    .i_op1(i_op1), .i_wr_en(i_wr_en), .o_valid(o_valid), .o_space(o_space), .o_addr(o_addr),
    .o_imm(o_imm), .o_bit_idx(o_bit_idx), .o_cycles(o_cycles), .o_reserved(o_reserved),
    .o_acc(o_acc), .o_data_pointer_reg(o_data_pointer_reg), .o_bank(o_bank));

`default_nettype wire

/* File: tb/coar_wb_model.sv */
`default_nettype none

module coar_wb_model (
    // clock
    input wire logic i_clk_sys,
    // write-back into the resolver
    output logic o_wr_en,
    output logic o_wr_sfr,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_wr_en = 1'b0;
        o_wr_sfr = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // one strobe per write; released address and data lines flip so stale values never match by luck
    task automatic write(input logic special_function_regs, input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        o_wr_en <= 1'b1;
        o_wr_sfr <= special_function_regs;
        o_wr_addr <= addr;
        o_wr_data <= data;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        o_wr_addr <= ~addr;
        o_wr_data <= ~data;
    endtask : write
endmodule : coar_wb_model

`default_nettype wire

/* File: tb/coar_resolver_test.sv */
`default_nettype none

module coar_resolver_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_dec_valid = 1'b0;
    logic [7:0] i_opcode = 8'h00, i_op1 = 8'h00, i_op2 = 8'h00;
    logic [15:0] i_pc = 16'h0000;
    logic wr_en, wr_sfr;
    logic [7:0] wr_addr, wr_data, o_acc;
    logic o_valid, o_reserved;
    coar_pkg::coar_space_t o_space;
    logic [15:0] o_addr, o_imm, o_data_pointer_reg;
    logic [2:0] o_bit_idx, o_cycles;
    logic [1:0] o_bank;
    int error_cnt = 0;
    int checks_done = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    coar_resolver coar_resolver_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_dec_valid(i_dec_valid), .i_opcode(i_opcode), .i_op1(i_op1), .i_op2(i_op2),
        .i_pc(i_pc), .i_wr_en(wr_en), .i_wr_sfr(wr_sfr), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_valid(o_valid), .o_space(o_space), .o_addr(o_addr),
        .o_imm(o_imm), .o_bit_idx(o_bit_idx), .o_cycles(o_cycles), .o_reserved(o_reserved),
        .o_acc(o_acc), .o_data_pointer_reg(o_data_pointer_reg), .o_bank(o_bank));
    coar_wb_model coar_wb_model_inst (.i_clk_sys(i_clk_sys), .o_wr_en(wr_en),
        .o_wr_sfr(wr_sfr), .o_wr_addr(wr_addr), .o_wr_data(wr_data));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // result lands on the taking edge itself and is read 1 ns after it
    task automatic dec(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
        @(posedge i_clk_sys);
        i_dec_valid <= 1'b1;
        i_opcode <= op;
        i_op1 <= a;
        i_op2 <= b;
        @(posedge i_clk_sys);
        i_dec_valid <= 1'b0;
        #1 check(16'(o_valid), 16'h0001);
    endtask : dec
    task automatic res(input coar_pkg::coar_space_t sp, input logic [15:0] addr);
        check(16'(o_space), 16'(sp));
        check(o_addr, addr);
    endtask : res

    task automatic t_reset();
        check({o_acc, 6'h00, o_bank}, 16'h0000);
        check(o_data_pointer_reg, 16'h0000);
        dec(8'hE6, 8'h00, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h0000);
    endtask : t_reset
    task automatic t_direct();
        dec(8'hE5, 8'h7F, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h007F);
        dec(8'hE5, 8'h80, 8'h00);
        res(coar_pkg::SP_SFR, 16'h0080);
    endtask : t_direct
    task automatic t_bank();
        coar_wb_model_inst.write(1'b1, 8'hD0, 8'h08);
        coar_wb_model_inst.write(1'b0, 8'h08, 8'h40);
        coar_wb_model_inst.write(1'b0, 8'h00, 8'h66);
        #1;
        check(16'(o_bank), 16'h0001);
        dec(8'h09, 8'h00, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h0009);
        dec(8'hE6, 8'h00, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h0040);
        dec(8'hE2, 8'h00, 8'h00);
        res(coar_pkg::SP_XDATA, 16'h0040);
        dec(8'hE8, 8'h00, 8'h00);
        check(16'(o_cycles), 16'h0001);
    endtask : t_bank
    task automatic t_data_pointer_reg();
        coar_wb_model_inst.write(1'b1, 8'h82, 8'h34);
        coar_wb_model_inst.write(1'b1, 8'h83, 8'h12);
        coar_wb_model_inst.write(1'b1, 8'hE0, 8'h05);
        dec(8'hE0, 8'h00, 8'h00);
        res(coar_pkg::SP_XDATA, 16'h1234);
        dec(8'h93, 8'h00, 8'h00);
        res(coar_pkg::SP_CODE, 16'h1239);
        @(posedge i_clk_sys);
        i_pc <= 16'h1000;
        dec(8'h83, 8'h00, 8'h00);
        res(coar_pkg::SP_CODE, 16'h1005);
        dec(8'h90, 8'hAB, 8'hCD);
        check(o_imm, 16'hABCD);
        dec(8'hE4, 8'h00, 8'h00);
        res(coar_pkg::SP_ACC, 16'h00E0);
        dec(8'h74, 8'h5A, 8'h00);
        check(o_imm, 16'h005A);
    endtask : t_data_pointer_reg
    // reset in mid-run, after bank, pointer, data pointer and accumulator were all loaded
    task automatic t_midreset();
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1;
        check({o_acc, 6'h00, o_bank}, 16'h0000);
        check(o_data_pointer_reg, 16'h0000);
        check(16'(o_space), 16'(coar_pkg::SP_NONE));
        dec(8'hE6, 8'h00, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h0000);
        dec(8'h93, 8'h00, 8'h00);
        res(coar_pkg::SP_CODE, 16'h0000);
    endtask : t_midreset
    task automatic t_misc();
        dec(8'hD3, 8'h00, 8'h00);
        res(coar_pkg::SP_BIT, 16'h00D0);
        check(16'(o_bit_idx), 16'h0007);
        dec(8'h75, 8'h30, 8'h99);
        res(coar_pkg::SP_IRAM, 16'h0030);
        check(o_imm, 16'h0099);
        dec(8'h7A, 8'h5A, 8'h00);
        res(coar_pkg::SP_IRAM, 16'h0002);
        check(o_imm, 16'h005A);
        dec(8'hA3, 8'h00, 8'h00);
        check(16'(o_space), 16'(coar_pkg::SP_DATA_POINTER_REG));
        dec(8'hD4, 8'h00, 8'h00);
        check(16'(o_cycles), 16'h0003);
    endtask : t_misc
    task automatic t_bits();
        logic [7:0] b [4] = '{8'h00, 8'h7F, 8'h80, 8'hD7};
        logic [15:0] ea [4] = '{16'h0020, 16'h002F, 16'h0080, 16'h00D0};
        for (int k = 0; k < 4; k++) begin
            dec(8'hC2, b[k], 8'h00);
            res(coar_pkg::SP_BIT, ea[k]);
            check(16'(o_bit_idx), 16'(b[k][2:0]));
        end
    endtask : t_bits
    // every opcode back to back, one result per cycle
    task automatic t_sweep();
        for (int i = 0; i <= 256; i++) begin
            @(posedge i_clk_sys);
            i_dec_valid <= (i < 256);
            i_opcode <= 8'(i);
            #1;
            if (i > 0) begin
                check(16'(o_valid), 16'h0001);
                check(16'(o_reserved), 16'(i - 1 == 8'hA5));
                if (i - 1 == 8'h84) check(16'(o_cycles), 16'h0006);
            end
        end
    endtask : t_sweep

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        t_reset();
        t_direct();
        t_bank();
        t_data_pointer_reg();
        t_midreset();
        t_misc();
        t_bits();
        t_sweep();
        report_and_stop();
    end
endmodule : coar_resolver_test

`default_nettype wire
